// *** include/isrp_pkg.sv ***
`default_nettype none
package isrp_pkg;
	localparam int          DATA_W      = 8;
	localparam int          IDX_W       = 3;
	localparam int          NUM_RW      = 4;
	localparam int          SYNC_W      = 3;
	localparam logic [6:0]  SLAVE_ADDR  = 7'h6b;
	localparam logic        DIR_WRITE   = 1'h1;
	localparam logic [4:0]  HS_CODE_TOP = 5'h01;
	localparam logic [4:0]  PTR_HI_ZERO = 5'h00;
	localparam logic [3:0]  BIT_FIRST   = 4'h1;
	localparam logic [3:0]  BIT_LAST    = 4'h7;
	localparam logic [3:0]  BIT_ACK     = 4'h8;
	localparam logic [2:0]  IDX_STATUS  = 3'h0;
	localparam logic [2:0]  IDX_LAST    = 3'h4;
	localparam logic [7:0]  UNMAPPED_RD = 8'hff;
	localparam logic [7:0]  RW_RST      = 8'h00;
	localparam logic [7:0]  STATUS_RST  = 8'h00;
	localparam int          RATE_STD    = 100000;
	localparam int          RATE_FAST   = 400000;
	localparam int          RATE_HS_WR  = 3400000;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_ADDR  = 5'b00010,
		ST_REG   = 5'b00100,
		ST_WDATA = 5'b01000,
		ST_READ  = 5'b10000
	} isrp_state_e;
endpackage : isrp_pkg
`default_nettype wire

// *** logic/isrp_sync3.sv ***
`timescale 1ns/10ps
`default_nettype none
module isrp_sync3 #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic [W-1:0] i_d,
	output var  logic [W-1:0] o_q
);
	logic [W-1:0] ff1_r;
	logic [W-1:0] ff2_r;
	logic [W-1:0] ff3_r;

	// A new value is taken once the second and third stages agree.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ff1_r <= '0;
			ff2_r <= '0;
			ff3_r <= '0;
			o_q   <= '0;
		end else begin
			ff1_r <= i_d;
			ff2_r <= ff1_r;
			ff3_r <= ff2_r;
			if (ff2_r == ff3_r) begin
				o_q <= ff3_r;
			end
		end
	end
endmodule : isrp_sync3
`default_nettype wire

// *** logic/isrp_cond_det.sv ***
`timescale 1ns/10ps
`default_nettype none
module isrp_cond_det (
	input  wire logic i_rst_n,
	input  wire logic i_scl,
	input  wire logic i_sda,
	output var  logic o_start_tgl,
	output var  logic o_stop_tgl
);
	// Falling data with the clock high flips the start toggle.
	always_ff @(negedge i_sda or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_start_tgl <= 1'h0;
		end else if (i_scl) begin
			o_start_tgl <= ~o_start_tgl;
		end
	end

	// Rising data with the clock high flips the stop toggle.
	always_ff @(posedge i_sda or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_stop_tgl <= 1'h0;
		end else if (i_scl) begin
			o_stop_tgl <= ~o_stop_tgl;
		end
	end
endmodule : isrp_cond_det
`default_nettype wire

// *** logic/isrp_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module isrp_top (
	input  wire logic                        i_clk,
	input  wire logic                        i_rst_n,
	input  wire logic                        i_scl,
	input  wire logic                        i_sda_in,
	output var  logic                        o_sda_out,
	output var  logic                        o_sda_oe,
	input  wire logic [isrp_pkg::DATA_W-1:0] i_status,
	output var  logic [isrp_pkg::DATA_W-1:0] o_reg1,
	output var  logic [isrp_pkg::DATA_W-1:0] o_reg2,
	output var  logic [isrp_pkg::DATA_W-1:0] o_reg3,
	output var  logic [isrp_pkg::DATA_W-1:0] o_reg4,
	output var  logic                        o_wr_stb,
	output var  logic [isrp_pkg::IDX_W-1:0]  o_wr_idx,
	output var  logic [isrp_pkg::DATA_W-1:0] o_wr_data,
	output var  logic                        o_hs_mode,
	output var  logic                        o_busy
);
	import isrp_pkg::*;

	// ****************************************************************
	// Declarations.
	// ****************************************************************
	isrp_state_e        state_r;
	logic [3:0]         cnt_r;
	logic [6:0]         shreg_r;
	logic               ack_r;
	logic [DATA_W-1:0]  ptr_r;
	logic               hs_r;
	logic               start_ack_r;
	logic               stop_ack_r;
	logic               wr_pend_r;
	logic               wr_req_r;
	logic               wr_tgl_r;
	logic [IDX_W-1:0]   wr_idx_r;
	logic [DATA_W-1:0]  wr_dat_r;
	logic [DATA_W-1:0]  tx_r;
	logic               drive_r;
	logic [DATA_W-1:0]  mirror_r [NUM_RW];
	logic [DATA_W-1:0]  regs_r   [NUM_RW];
	logic               wr_seen_r;
	logic               start_tgl;
	logic               stop_tgl;
	logic               start_pend;
	logic               stop_pend;
	logic [DATA_W-1:0]  rx_byte;
	logic [DATA_W-1:0]  rd_byte;
	logic [DATA_W-1:0]  status_s;
	logic               ptr_ok;
	logic               ptr_wr_ok;
	logic [SYNC_W-1:0]  sys_q;
	logic               busy_lvl;

	function automatic logic [1:0] slot(input logic [IDX_W-1:0] idx);
		slot = 2'(idx - 3'h1);
	endfunction : slot

	// ****************************************************************
	// Bus condition detection and status crossing onto the link clock.
	// ****************************************************************
	isrp_cond_det u_cond (
		.i_rst_n     (i_rst_n),
		.i_scl       (i_scl),
		.i_sda       (i_sda_in),
		.o_start_tgl (start_tgl),
		.o_stop_tgl  (stop_tgl)
	);

	isrp_sync3 #(.W(DATA_W)) u_status_sync (
		.i_clk   (i_scl),
		.i_rst_n (i_rst_n),
		.i_d     (i_status),
		.o_q     (status_s)
	);

	assign start_pend = start_tgl != start_ack_r;
	assign stop_pend  = stop_tgl != stop_ack_r;
	assign rx_byte    = {shreg_r, i_sda_in};
	assign ptr_ok     = (ptr_r[7:3] == PTR_HI_ZERO) && (ptr_r[2:0] <= IDX_LAST);
	assign ptr_wr_ok  = ptr_ok && (ptr_r[2:0] != IDX_STATUS);
	// A start reads as busy and a stop as idle at once, ahead of the next clock.
	assign busy_lvl   = start_pend | ((state_r != ST_IDLE) & ~stop_pend);

	// ****************************************************************
	// Read data selection.
	// ****************************************************************
	always_comb begin
		if (!ptr_ok) begin
			rd_byte = UNMAPPED_RD;
		end else if (ptr_r[2:0] == IDX_STATUS) begin
			rd_byte = status_s;
		end else begin
			rd_byte = mirror_r[slot(ptr_r[2:0])];
		end
	end

	// ****************************************************************
	// Link sequencer on the rising serial clock edge.
	// ****************************************************************
	always_ff @(posedge i_scl or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_r     <= ST_IDLE;
			cnt_r       <= 4'h0;
			shreg_r     <= 7'h00;
			ack_r       <= 1'h0;
			ptr_r       <= 8'h00;
			hs_r        <= 1'h0;
			start_ack_r <= 1'h0;
			stop_ack_r  <= 1'h0;
			wr_pend_r   <= 1'h0;
			wr_req_r    <= 1'h0;
			wr_idx_r    <= 3'h0;
			wr_dat_r    <= 8'h00;
			tx_r        <= 8'h00;
		end else if (start_pend) begin
			start_ack_r <= start_tgl;
			stop_ack_r  <= stop_tgl;
			if (stop_pend) begin
				hs_r <= 1'h0;
			end
			state_r     <= ST_ADDR;
			cnt_r       <= BIT_FIRST;
			shreg_r     <= {6'h00, i_sda_in};
			ack_r       <= 1'h0;
			wr_pend_r   <= 1'h0;
		end else if (stop_pend) begin
			stop_ack_r  <= stop_tgl;
			state_r     <= ST_IDLE;
			cnt_r       <= 4'h0;
			ack_r       <= 1'h0;
			wr_pend_r   <= 1'h0;
			hs_r        <= 1'h0;
		end else if (state_r != ST_IDLE) begin
			if (cnt_r == BIT_ACK) begin
				cnt_r <= 4'h0;
				ack_r <= 1'h0;
				if (wr_pend_r) begin
					wr_req_r  <= ~wr_req_r;
					wr_pend_r <= 1'h0;
				end
				if (state_r == ST_READ) begin
					if (i_sda_in) begin
						state_r <= ST_IDLE;
					end else begin
						tx_r <= rd_byte;
					end
				end
			end else begin
				cnt_r   <= cnt_r + 4'h1;
				shreg_r <= rx_byte[6:0];
				if (cnt_r == BIT_LAST) begin
					case (state_r)
						ST_ADDR: begin
							if (rx_byte[7:1] == SLAVE_ADDR) begin
								ack_r <= 1'h1;
								if (rx_byte[0] == DIR_WRITE) begin
									state_r <= ST_REG;
								end else begin
									state_r <= ST_READ;
								end
							end else if (rx_byte[7:3] == HS_CODE_TOP) begin
								hs_r    <= 1'h1;
								state_r <= ST_IDLE;
							end else begin
								state_r <= ST_IDLE;
							end
						end
						ST_REG: begin
							ptr_r   <= rx_byte;
							ack_r   <= 1'h1;
							state_r <= ST_WDATA;
						end
						ST_WDATA: begin
							wr_idx_r  <= ptr_r[2:0];
							wr_dat_r  <= rx_byte;
							wr_pend_r <= ptr_wr_ok;
							ack_r     <= 1'h1;
							state_r   <= ST_REG;
						end
						ST_READ: begin
							ack_r <= 1'h0;
						end
						default: begin
							state_r <= ST_IDLE;
						end
					endcase
				end
			end
		end
	end

	// ****************************************************************
	// Data line drive on the falling serial clock edge.
	// ****************************************************************
	always_ff @(negedge i_scl or negedge i_rst_n) begin
		if (!i_rst_n) begin
			drive_r <= 1'h0;
		end else if (start_pend || stop_pend) begin
			drive_r <= 1'h0;
		end else if (cnt_r == BIT_ACK) begin
			drive_r <= ack_r;
		end else if (state_r == ST_READ) begin
			drive_r <= ~tx_r[~cnt_r[2:0]];
		end else begin
			drive_r <= 1'h0;
		end
	end

	// ****************************************************************
	// Register copies on the link side.
	// ****************************************************************
	// Write commits on the falling edge that ends the acknowledge.
	always_ff @(negedge i_scl or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_tgl_r <= 1'h0;
			for (int i = 0; i < NUM_RW; i++) begin
				mirror_r[i] <= RW_RST;
			end
		end else begin
			wr_tgl_r <= wr_req_r;
			if (wr_tgl_r != wr_req_r) begin
				mirror_r[slot(wr_idx_r)] <= wr_dat_r;
			end
		end
	end

	// Only a low level is ever driven; a pending stop or start lets go at once.
	assign o_sda_out = 1'h0;
	assign o_sda_oe  = drive_r & ~stop_pend & ~start_pend;

	// ****************************************************************
	// Crossing into the system clock domain.
	// ****************************************************************
	isrp_sync3 #(.W(SYNC_W)) u_sys_sync (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_d     ({hs_r & ~stop_pend, busy_lvl, wr_tgl_r}),
		.o_q     (sys_q)
	);

	assign o_hs_mode = sys_q[2];
	assign o_busy    = sys_q[1];

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_seen_r <= 1'h0;
			o_wr_stb  <= 1'h0;
			o_wr_idx  <= 3'h0;
			o_wr_data <= 8'h00;
		end else begin
			wr_seen_r <= sys_q[0];
			o_wr_stb  <= sys_q[0] != wr_seen_r;
			if (sys_q[0] != wr_seen_r) begin
				o_wr_idx  <= wr_idx_r;
				o_wr_data <= wr_dat_r;
			end
		end
	end

	// ****************************************************************
	// Register copies in the system clock domain.
	// ****************************************************************
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 0; i < NUM_RW; i++) begin
				regs_r[i] <= RW_RST;
			end
		end else if (sys_q[0] != wr_seen_r) begin
			regs_r[slot(wr_idx_r)] <= wr_dat_r;
		end
	end

	assign o_reg1 = regs_r[0];
	assign o_reg2 = regs_r[1];
	assign o_reg3 = regs_r[2];
	assign o_reg4 = regs_r[3];
endmodule : isrp_top
`default_nettype wire

// *** bench/isrp_top_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module isrp_top_asserts (
	input wire logic       i_clk,
	input wire logic       i_rst_n,
	input wire logic       i_scl,
	input wire logic       i_sda_in,
	input wire logic       o_sda_oe,
	input wire logic [7:0] o_reg1,
	input wire logic [7:0] o_reg4,
	input wire logic       o_wr_stb,
	input wire logic [2:0] o_wr_idx,
	input wire logic [7:0] o_wr_data,
	input wire logic       o_hs_mode,
	input wire logic       o_busy
);
	// ****************
	// Link checks.
	// ****************
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	sequence s_start;
		i_scl && $past(i_scl) && $fell(i_sda_in);
	endsequence
	sequence s_stop;
		i_scl && $past(i_scl) && $rose(i_sda_in);
	endsequence
	a_stb_single: assert property (o_wr_stb |=> !o_wr_stb [*8])
		else $error("write strobe repeated");
	a_stb_index: assert property (o_wr_stb |-> o_wr_idx >= 3'h1 && o_wr_idx <= 3'h4)
		else $error("write strobe to bad index");
	a_reg1_cause: assert property ($changed(o_reg1) |->
		o_wr_stb && o_wr_idx == 3'h1 && o_reg1 == o_wr_data)
		else $error("reg1 changed without write");
	a_reg4_cause: assert property ($changed(o_reg4) |->
		o_wr_stb && o_wr_idx == 3'h4 && o_reg4 == o_wr_data)
		else $error("reg4 changed without write");
	a_stop_release: assert property (s_stop |-> !o_sda_oe)
		else $error("data held after stop");
	a_oe_high_steady: assert property (i_scl && $past(i_scl) |-> !$rose(o_sda_oe))
		else $error("data pulled while clock high");
	a_start_busy: assert property (s_start |-> ##[1:8] o_busy)
		else $error("start not seen");
	a_stop_idle: assert property (s_stop |-> ##[1:8] !o_busy)
		else $error("stop not seen");
	a_stop_hs_clear: assert property (s_stop |-> ##[1:8] !o_hs_mode)
		else $error("high speed kept after stop");
endmodule : isrp_top_asserts
bind isrp_top isrp_top_asserts isrp_top_asserts_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
	.i_scl(i_scl), .i_sda_in(i_sda_in), .o_sda_oe(o_sda_oe), .o_reg1(o_reg1),
	.o_reg4(o_reg4), .o_wr_stb(o_wr_stb), .o_wr_idx(o_wr_idx), .o_wr_data(o_wr_data),
	.o_hs_mode(o_hs_mode), .o_busy(o_busy));
`default_nettype wire

// *** bench/isrp_master.sv ***
`timescale 1ns/10ps
`default_nettype none
module isrp_master (
	output var logic  o_scl,
	output var logic  o_sda_low,
	input  wire logic i_sda
);
	// ****************
	// Bus master model.
	// ****************
	localparam realtime Q = 31.25;
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end
	task automatic start_c;
		o_sda_low = 1'b0;
		#Q o_scl = 1'b1;
		#Q o_sda_low = 1'b1;
		#Q o_scl = 1'b0;
		#Q;
	endtask : start_c
	task automatic stop_c;
		o_sda_low = 1'b1;
		#Q o_scl = 1'b1;
		#Q o_sda_low = 1'b0;
		#(4*Q);
	endtask : stop_c
	task automatic bit_x(input logic b, output logic r);
		o_sda_low = !b;
		#Q o_scl = 1'b1;
		#Q r = i_sda;
		#Q o_scl = 1'b0;
		#Q;
	endtask : bit_x
	task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
		output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], r);
			q[i] = r;
		end
		bit_x(ack_in, ack);
	endtask : xfer
endmodule : isrp_master
`default_nettype wire

// *** bench/isrp_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module isrp_bench;
	import isrp_pkg::*;
	logic       i_clk;
	logic       i_rst_n;
	logic       scl;
	logic       m_low;
	logic       sda;
	logic       sda_out;
	logic       sda_oe;
	logic [7:0] status;
	logic [7:0] reg1;
	logic [7:0] reg2;
	logic [7:0] reg3;
	logic [7:0] reg4;
	logic [7:0] wr_data;
	logic [2:0] wr_idx;
	logic       wr_stb;
	logic       hs;
	logic       busy;
	int         n_errors;
	int         num_checks;
	// ****************
	// Bench body.
	// ****************
	assign sda = !(m_low || (sda_oe && !sda_out));
	initial i_clk = 1'b0;
	always #10 i_clk = !i_clk;
	isrp_top isrp_top_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda_in(sda),
		.o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_status(status), .o_reg1(reg1),
		.o_reg2(reg2), .o_reg3(reg3), .o_reg4(reg4), .o_wr_stb(wr_stb), .o_wr_idx(wr_idx),
		.o_wr_data(wr_data), .o_hs_mode(hs), .o_busy(busy));
	isrp_master isrp_master_inst (.o_scl(scl), .o_sda_low(m_low), .i_sda(sda));
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic end_sim;
		if (n_errors == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_sim
	task automatic wb(input logic [7:0] d, input logic exp_ack);
		logic [7:0] q;
		logic       a;
		isrp_master_inst.xfer(d, 1'b1, q, a);
		chk("ack", {7'h00, a}, {7'h00, exp_ack});
	endtask : wb
	task automatic rb(input logic mack, input logic [7:0] exp);
		logic [7:0] q;
		logic       a;
		isrp_master_inst.xfer(8'hff, mack, q, a);
		chk("rdata", q, exp);
	endtask : rb
	task automatic settle;
		repeat (10) @(negedge i_clk);
	endtask : settle
	task automatic t_write;
		isrp_master_inst.start_c();
		wb(8'hd7, 1'b0);
		wb(8'h01, 1'b0);
		wb(8'h3c, 1'b0);
		wb(8'h03, 1'b0);
		wb(8'ha5, 1'b0);
		wb(8'h04, 1'b0);
		wb(8'hc3, 1'b0);
		isrp_master_inst.stop_c();
		settle();
		chk("reg1", reg1, 8'h3c);
		chk("reg3", reg3, 8'ha5);
		chk("reg4", reg4, 8'hc3);
		chk("wr_idx", {5'h00, wr_idx}, 8'h04);
		chk("wr_data", wr_data, 8'hc3);
		chk("busy", {7'h00, busy}, 8'h00);
	endtask : t_write
	task automatic t_read;
		isrp_master_inst.start_c();
		wb(8'hd7, 1'b0);
		wb(8'h01, 1'b0);
		isrp_master_inst.start_c();
		wb(8'hd6, 1'b0);
		rb(1'b0, 8'h3c);
		rb(1'b1, 8'h3c);
		isrp_master_inst.stop_c();
	endtask : t_read
	task automatic t_odd_regs;
		@(negedge i_clk);
		status = 8'h5a;
		isrp_master_inst.start_c();
		wb(8'hd7, 1'b0);
		wb(8'h21, 1'b0);
		wb(8'h77, 1'b0);
		wb(8'h00, 1'b0);
		wb(8'h11, 1'b0);
		wb(8'h06, 1'b0);
		isrp_master_inst.start_c();
		wb(8'hd6, 1'b0);
		rb(1'b1, 8'hff);
		isrp_master_inst.start_c();
		wb(8'hd7, 1'b0);
		wb(8'h00, 1'b0);
		isrp_master_inst.start_c();
		wb(8'hd6, 1'b0);
		rb(1'b1, 8'h5a);
		isrp_master_inst.stop_c();
		chk("reg1", reg1, 8'h3c);
	endtask : t_odd_regs
	task automatic t_wrong_addr;
		isrp_master_inst.start_c();
		wb(8'hd5, 1'b1);
		wb(8'h02, 1'b1);
		isrp_master_inst.stop_c();
	endtask : t_wrong_addr
	task automatic t_hs;
		isrp_master_inst.start_c();
		wb(8'h0b, 1'b1);
		settle();
		chk("hs", {7'h00, hs}, 8'h01);
		isrp_master_inst.start_c();
		wb(8'hd7, 1'b0);
		wb(8'h02, 1'b0);
		wb(8'h99, 1'b0);
		isrp_master_inst.stop_c();
		settle();
		chk("hs", {7'h00, hs}, 8'h00);
		chk("reg2", reg2, 8'h99);
	endtask : t_hs
	task automatic t_abort;
		logic r;
		isrp_master_inst.start_c();
		wb(8'hd7, 1'b0);
		repeat (3) isrp_master_inst.bit_x(1'b0, r);
		isrp_master_inst.stop_c();
		isrp_master_inst.start_c();
		wb(8'hd6, 1'b0);
		rb(1'b1, 8'h99);
		isrp_master_inst.stop_c();
	endtask : t_abort
	initial begin
		i_rst_n = 1'b0;
		status = 8'h00;
		n_errors = 0;
		num_checks = 0;
		repeat (8) @(negedge i_clk);
		chk("reg1", reg1, 8'h00);
		chk("oe", {7'h00, sda_oe}, 8'h00);
		chk("sda_out", {7'h00, sda_out}, 8'h00);
		i_rst_n = 1'b1;
		#7;
		t_write();
		t_read();
		t_odd_regs();
		t_wrong_addr();
		t_hs();
		t_abort();
		end_sim();
	end
	initial begin
		#300000;
		n_errors++;
		end_sim();
	end
endmodule : isrp_bench
`default_nettype wire
